// ==== core/ofl_params.svh ====
// Constants for the oscillator, PLL and frequency loop configuration block
// Overview of operation
// [RQ1] Monitor sets failure flag; write one clears
// [RQ2] Enable arms monitor; set flag raises NMI
// [RQ3] Enable writable under protection, cleared by reset
// [RQ4] Slow trim loaded from signature, stays writable
// [RQ5] PLL source: 00 mid, 10 fast, 11 external
// [RQ6] Software avoids crystal pins, external at least 0.4MHz
// [RQ7] Half-output bit halves PLL output
// [RQ8] Five-bit multiplier in bits 4:0, 1x-31x
// [RQ9] Fast loop reference: internal, crystal, USB frame
// [RQ10] Mid loop reference bit, zero selects internal
// [RQ11] Software enables chosen reference source separately
// [RQ12] Loop enable starts automatic calibration
// [RQ13] Enable reads one until loop stops
// [RQ14] Fine and coarse form 13-bit calibration
// [RQ15] Calibration writes ignored while loop enabled
// [RQ16] Loop steps fine field only, coarse fixed
// [RQ17] Fine and coarse loaded from signature at reset
// [RQ18] Software sets fine mid value for new targets
// [RQ19] 16-bit compare ratio, low byte offset 0x05
// [RQ20] Compare high byte at 0x06, resets zero
// [RQ21] Loop counts, compares, steps fine field
// [RQ22] Failure when no edge within fixed timeout
`ifndef OFL_PARAMS_SVH
`define OFL_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets: oscillator space at 0x0, loop space at 0x8
// ----------------------------------------------------------------
`define OFL_LOOP_BASE 4'h8
`define OFL_ADDR_FAIL 4'h3
`define OFL_ADDR_TRIM 4'h4
`define OFL_ADDR_PLL 4'h5
`define OFL_ADDR_REFSEL 4'h6
`define OFL_ADDR_CTRL 4'h8
`define OFL_ADDR_FINE 4'ha
`define OFL_ADDR_COARSE 4'hb
`define OFL_ADDR_CMP_LO 4'hd
`define OFL_ADDR_CMP_HI 4'he

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OFL_FAIL_FLAG_BIT 1
`define OFL_FAIL_EN_BIT 0
`define OFL_LOOP_EN_BIT 0
`define OFL_MID_REF_BIT 0
`define OFL_FAST_REF_LSB 1
`define OFL_PLL_SRC_MID 2'b00
`define OFL_PLL_SRC_FAST 2'b10
`define OFL_PLL_SRC_EXT 2'b11
`define OFL_REF_SLOW_OSC 2'b00
`define OFL_REF_CRYSTAL 2'b01
`define OFL_REF_USB_SOF 2'b10

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define OFL_RST_BYTE 8'h00
`define OFL_FINE_MAX 7'h7f
`define OFL_FINE_MIN 7'h00
`define OFL_CNT_MAX 16'hffff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OFL_CLK_PERIOD_NS 100
`define OFL_FAIL_TIMEOUT_NS 10000
`define OFL_FAIL_TIMEOUT_CYC (`OFL_FAIL_TIMEOUT_NS / `OFL_CLK_PERIOD_NS)

`endif

// ==== core/ofl_pkg.sv ====
// Types shared by the oscillator and frequency loop configuration block
package ofl_pkg;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ofl_bus_t;

  typedef struct packed
  {
    logic [1:0] pll_input_select;
    logic pll_half_output;
    logic [4:0] pll_multiplier;
  } ofl_pll_t;

  typedef struct packed
  {
    logic [7:0] slow_osc_trim_value;
    logic [6:0] loop_fine_trim;
    logic [5:0] loop_coarse_trim;
  } ofl_factory_t;

  typedef enum logic [1:0]
  {
    LOOP_IDLE,
    LOOP_START,
    LOOP_RUN,
    LOOP_STOPPING
  } ofl_loop_state_t;

endpackage

// ==== core/ofl_top.sv ====
// Oscillator, PLL and frequency loop configuration registers with loop engine
`timescale 1ns/1ps
`include "ofl_params.svh"

module ofl_top
  import ofl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire ofl_bus_t bus_req,
  output logic [7:0] rdata,
  input wire logic cfg_unlock,
  input wire ofl_factory_t factory,
  input wire logic ext_clk_in,
  input wire logic osc_tick,
  input wire logic ref_slow_osc,
  input wire logic ref_slow_crystal,
  input wire logic ref_usb_sof,
  output logic ext_clk_fail_nmi,
  output ofl_pll_t pll_cfg,
  output logic pll_src_reserved,
  output logic fast_osc_loop_ref_sel0,
  output logic fast_osc_loop_ref_sel1,
  output logic mid_osc_loop_ref,
  output logic [7:0] slow_osc_trim_value,
  output logic [12:0] osc_cal,
  output logic loop_running
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input ofl_bus_t b, input logic [3:0] a);
    hit = b.addr == a;
  endfunction

  function automatic logic [6:0] fine_step(input logic [6:0] v, input logic up);
    if (up)
    begin
      fine_step = (v == `OFL_FINE_MAX) ? v : v + 7'h01;
    end
    else
    begin
      fine_step = (v == `OFL_FINE_MIN) ? v : v - 7'h01;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic load_reg, load_next;
  logic fail_en_reg, fail_en_next;
  logic fail_flag_reg, fail_flag_next;
  logic ext_d_reg, ext_d_next;
  logic [15:0] wd_cnt_reg, wd_cnt_next;
  logic [7:0] trim_reg, trim_next;
  ofl_pll_t pll_reg, pll_next;
  logic [1:0] fast_ref_reg, fast_ref_next;
  logic mid_ref_reg, mid_ref_next;
  logic loop_en_reg, loop_en_next;
  logic [6:0] fine_reg, fine_next;
  logic [5:0] coarse_reg, coarse_next;
  logic [7:0] cmp_lo_reg, cmp_lo_next;
  logic [7:0] cmp_hi_reg, cmp_hi_next;
  logic [15:0] cnt_reg, cnt_next;
  ofl_loop_state_t st_reg, st_next;
  logic [7:0] rdata_reg, rdata_next;

  logic ref_tick;
  logic ext_edge;
  logic loop_busy;
  logic cal_lock;
  logic [15:0] cmp_val;

  // ----------------------------------------------------------------
  // Reference routing
  // ----------------------------------------------------------------
  always_comb
  begin
    case (fast_ref_reg)
      `OFL_REF_SLOW_OSC: ref_tick = ref_slow_osc; // see [RQ9]
      `OFL_REF_CRYSTAL: ref_tick = ref_slow_crystal; // see [RQ9]
      `OFL_REF_USB_SOF: ref_tick = ref_usb_sof; // see [RQ9]
      default: ref_tick = 1'b0;
    endcase
  end

  assign ext_edge = ext_clk_in ^ ext_d_reg;
  assign loop_busy = st_reg != LOOP_IDLE;
  // A running or draining loop owns the trim, so software must not race it
  assign cal_lock = loop_en_reg | loop_busy; // see [RQ15]
  assign cmp_val = {cmp_hi_reg, cmp_lo_reg}; // see [RQ19] see [RQ20]

  // ----------------------------------------------------------------
  // Failure monitor and configuration registers
  // ----------------------------------------------------------------
  always_comb
  begin
    load_next = 1'b0;
    fail_en_next = fail_en_reg;
    fail_flag_next = fail_flag_reg;
    ext_d_next = ext_clk_in;
    wd_cnt_next = wd_cnt_reg;
    trim_next = trim_reg;
    pll_next = pll_reg;
    fast_ref_next = fast_ref_reg;
    mid_ref_next = mid_ref_reg;
    cmp_lo_next = cmp_lo_reg;
    cmp_hi_next = cmp_hi_reg;
    if (ext_edge)
    begin
      wd_cnt_next = 16'h0000;
    end
    else if (wd_cnt_reg != 16'(`OFL_FAIL_TIMEOUT_CYC))
    begin
      wd_cnt_next = wd_cnt_reg + 16'h0001;
    end
    if (load_reg)
    begin
      trim_next = factory.slow_osc_trim_value; // see [RQ4]
    end
    if (bus_req.wr)
    begin
      if (hit(bus_req, `OFL_ADDR_FAIL))
      begin
        if (bus_req.wdata[`OFL_FAIL_FLAG_BIT])
        begin
          fail_flag_next = 1'b0; // see [RQ1]
        end
        // Only a protected write may arm; nothing but reset disarms
        if (cfg_unlock && bus_req.wdata[`OFL_FAIL_EN_BIT])
        begin
          fail_en_next = 1'b1; // see [RQ3]
        end
      end
      if (hit(bus_req, `OFL_ADDR_TRIM))
      begin
        trim_next = bus_req.wdata; // see [RQ4]
      end
      if (hit(bus_req, `OFL_ADDR_PLL))
      begin
        pll_next = ofl_pll_t'(bus_req.wdata); // see [RQ5] see [RQ7] see [RQ8]
      end
      if (hit(bus_req, `OFL_ADDR_REFSEL))
      begin
        fast_ref_next = bus_req.wdata[`OFL_FAST_REF_LSB +: 2]; // see [RQ9]
        mid_ref_next = bus_req.wdata[`OFL_MID_REF_BIT]; // see [RQ10]
      end
      if (hit(bus_req, `OFL_ADDR_CMP_LO))
      begin
        cmp_lo_next = bus_req.wdata; // see [RQ19]
      end
      if (hit(bus_req, `OFL_ADDR_CMP_HI))
      begin
        cmp_hi_next = bus_req.wdata; // see [RQ20]
      end
    end
    // Detection after the clear so a same-cycle failure is kept
    if (fail_en_reg && !ext_edge && wd_cnt_reg == 16'(`OFL_FAIL_TIMEOUT_CYC))
    begin
      fail_flag_next = 1'b1; // see [RQ1] see [RQ22]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      load_reg <= 1'b1;
      fail_en_reg <= 1'b0;
      fail_flag_reg <= 1'b0;
      ext_d_reg <= 1'b0;
      wd_cnt_reg <= 16'h0000;
      trim_reg <= `OFL_RST_BYTE;
      pll_reg <= ofl_pll_t'(`OFL_RST_BYTE);
      fast_ref_reg <= 2'b00;
      mid_ref_reg <= 1'b0; // see [RQ10]
      cmp_lo_reg <= `OFL_RST_BYTE;
      cmp_hi_reg <= `OFL_RST_BYTE; // see [RQ20]
    end
    else
    begin
      load_reg <= load_next;
      fail_en_reg <= fail_en_next;
      fail_flag_reg <= fail_flag_next;
      ext_d_reg <= ext_d_next;
      wd_cnt_reg <= wd_cnt_next;
      trim_reg <= trim_next;
      pll_reg <= pll_next;
      fast_ref_reg <= fast_ref_next;
      mid_ref_reg <= mid_ref_next;
      cmp_lo_reg <= cmp_lo_next;
      cmp_hi_reg <= cmp_hi_next;
    end
  end

  // ----------------------------------------------------------------
  // Frequency loop engine and calibration registers
  // ----------------------------------------------------------------
  always_comb
  begin
    loop_en_next = loop_en_reg;
    fine_next = fine_reg;
    coarse_next = coarse_reg;
    cnt_next = cnt_reg;
    st_next = st_reg;
    if (load_reg)
    begin
      fine_next = factory.loop_fine_trim; // see [RQ17]
      coarse_next = factory.loop_coarse_trim; // see [RQ17]
    end
    if (bus_req.wr && hit(bus_req, `OFL_ADDR_CTRL))
    begin
      loop_en_next = bus_req.wdata[`OFL_LOOP_EN_BIT]; // see [RQ12]
    end
    if (bus_req.wr && !cal_lock && hit(bus_req, `OFL_ADDR_FINE))
    begin
      fine_next = bus_req.wdata[6:0]; // see [RQ15]
    end
    if (bus_req.wr && !cal_lock && hit(bus_req, `OFL_ADDR_COARSE))
    begin
      coarse_next = bus_req.wdata[5:0]; // see [RQ15]
    end
    if (osc_tick && cnt_reg != `OFL_CNT_MAX)
    begin
      cnt_next = cnt_reg + 16'h0001;
    end
    case (st_reg)
      LOOP_IDLE:
      begin
        if (loop_en_reg)
        begin
          st_next = LOOP_START; // see [RQ12]
        end
      end
      LOOP_START:
      begin
        // Wait for a reference edge so the first count spans a full period
        if (!loop_en_reg)
        begin
          st_next = LOOP_IDLE;
        end
        else if (ref_tick)
        begin
          cnt_next = 16'h0000;
          st_next = LOOP_RUN;
        end
      end
      LOOP_RUN:
      begin
        if (ref_tick)
        begin
          cnt_next = 16'h0000;
          if (cnt_reg != cmp_val)
          begin
            fine_next = fine_step(fine_reg, cnt_reg < cmp_val); // see [RQ21] see [RQ16]
          end
          if (!loop_en_reg)
          begin
            st_next = LOOP_IDLE;
          end
        end
        else if (!loop_en_reg)
        begin
          st_next = LOOP_STOPPING; // see [RQ13]
        end
      end
      LOOP_STOPPING:
      begin
        // Drain to the next reference edge; reference must keep running
        if (ref_tick)
        begin
          cnt_next = 16'h0000;
          st_next = LOOP_IDLE; // see [RQ13]
        end
      end
      default:
      begin
        st_next = LOOP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      loop_en_reg <= 1'b0;
      fine_reg <= 7'h00;
      coarse_reg <= 6'h00;
      cnt_reg <= 16'h0000;
      st_reg <= LOOP_IDLE;
    end
    else
    begin
      loop_en_reg <= loop_en_next;
      fine_reg <= fine_next;
      coarse_reg <= coarse_next;
      cnt_reg <= cnt_next;
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = `OFL_RST_BYTE;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `OFL_ADDR_FAIL: rdata_next = {6'h00, fail_flag_reg, fail_en_reg};
        `OFL_ADDR_TRIM: rdata_next = trim_reg;
        `OFL_ADDR_PLL: rdata_next = pll_reg;
        `OFL_ADDR_REFSEL: rdata_next = {5'h00, fast_ref_reg, mid_ref_reg};
        `OFL_ADDR_CTRL: rdata_next = {7'h00, loop_en_reg | loop_busy}; // see [RQ13]
        `OFL_ADDR_FINE: rdata_next = {1'b0, fine_reg};
        `OFL_ADDR_COARSE: rdata_next = {2'b00, coarse_reg};
        `OFL_ADDR_CMP_LO: rdata_next = cmp_lo_reg;
        `OFL_ADDR_CMP_HI: rdata_next = cmp_hi_reg;
        default: rdata_next = `OFL_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_reg <= `OFL_RST_BYTE;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = rdata_reg;
  assign ext_clk_fail_nmi = fail_en_reg & fail_flag_reg; // see [RQ2]
  assign pll_cfg = pll_reg; // see [RQ5] see [RQ7] see [RQ8]
  assign pll_src_reserved = pll_reg.pll_input_select == 2'b01; // see [RQ5]
  assign fast_osc_loop_ref_sel0 = fast_ref_reg[0];
  assign fast_osc_loop_ref_sel1 = fast_ref_reg[1];
  assign mid_osc_loop_ref = mid_ref_reg; // see [RQ10]
  assign slow_osc_trim_value = trim_reg;
  // Same value steers the oscillator in manual and automatic modes
  assign osc_cal = {coarse_reg, fine_reg}; // see [RQ14]
  assign loop_running = loop_busy;

endmodule

// ==== tb/ofl_osc_model.sv ====
// Behavioural model of the oscillators and reference clocks
`timescale 1ns/1ps
module ofl_osc_model
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ext_run,
  output logic ext_clk_in,
  output logic osc_tick,
  output logic ref_slow_osc,
  output logic ref_slow_crystal,
  output logic ref_usb_sof
);
  // ----------------------------------------
  // Sources
  // ----------------------------------------
  logic [7:0] cnt_reg;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= 8'h00;
      ext_clk_in <= 1'b0;
      osc_tick <= 1'b0;
      ref_slow_osc <= 1'b0;
      ref_slow_crystal <= 1'b0;
      ref_usb_sof <= 1'b0;
    end
    else
    begin
      cnt_reg <= (cnt_reg == 8'h13) ? 8'h00 : cnt_reg + 8'h01;
      // Ten oscillator ticks per reference period
      osc_tick <= cnt_reg[0];
      // References run free, so a loop stop never waits forever
      ref_slow_osc <= (cnt_reg == 8'h00);
      ref_slow_crystal <= (cnt_reg == 8'h05);
      ref_usb_sof <= (cnt_reg == 8'h0a);
      // External clock well above the PLL minimum; a stopped clock holds its level
      if (ext_run && cnt_reg[1:0] == 2'b11)
        ext_clk_in <= !ext_clk_in;
    end
  end
endmodule

// ==== tb/ofl_properties.sv ====
// Concurrent checks for the clock configuration block
`timescale 1ns/1ps
`include "ofl_params.svh"
module ofl_properties
  import ofl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire ofl_bus_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic ext_clk_in,
  input wire logic ext_clk_fail_nmi,
  input wire ofl_pll_t pll_cfg,
  input wire logic pll_src_reserved,
  input wire logic fast_osc_loop_ref_sel0,
  input wire logic fast_osc_loop_ref_sel1,
  input wire logic mid_osc_loop_ref,
  input wire logic [7:0] slow_osc_trim_value,
  input wire logic [12:0] osc_cal,
  input wire logic loop_running
);
  // ----------------------------------------
  // Quiet time of the external clock
  // ----------------------------------------
  logic ext_d_reg;
  logic [7:0] quiet_reg;
  logic [7:0] quiet_next;
  always_comb
  begin
    quiet_next = quiet_reg;
    if (ext_clk_in != ext_d_reg)
      quiet_next = 8'h00;
    else if (quiet_reg != 8'hff)
      quiet_next = quiet_reg + 8'h01;
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_d_reg <= 1'b0;
      quiet_reg <= 8'h00;
    end
    else
    begin
      ext_d_reg <= ext_clk_in;
      quiet_reg <= quiet_next;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence s_wr(logic [3:0] a);
    bus_req.wr && bus_req.addr == a;
  endsequence
  sequence s_loop_on;
    s_wr(`OFL_ADDR_CTRL) ##0 bus_req.wdata[0];
  endsequence
  a_pll_write: assert property (s_wr(`OFL_ADDR_PLL) |=> pll_cfg == $past(bus_req.wdata))
    else $error("pll setup differs from written byte");
  a_pll_reserved: assert property (pll_src_reserved == (pll_cfg.pll_input_select == 2'b01))
    else $error("reserved source flag wrong");
  a_trim_write: assert property (s_wr(`OFL_ADDR_TRIM) |=> slow_osc_trim_value == $past(bus_req.wdata))
    else $error("slow trim not written");
  a_ref_write: assert property (s_wr(`OFL_ADDR_REFSEL) |=>
    {fast_osc_loop_ref_sel1, fast_osc_loop_ref_sel0, mid_osc_loop_ref} == $past(bus_req.wdata[2:0]))
    else $error("reference select not written");
  a_fail_timeout: assert property ($rose(ext_clk_fail_nmi) |-> quiet_reg > 8'h5e)
    else $error("failure raised before timeout");
  a_nmi_holds: assert property (ext_clk_fail_nmi &&
    !(bus_req.wr && bus_req.addr == `OFL_ADDR_FAIL && bus_req.wdata[1]) |=> ext_clk_fail_nmi)
    else $error("failure interrupt dropped without clear");
  a_pll_readback: assert property (bus_req.rd && bus_req.addr == `OFL_ADDR_PLL |=> rdata == pll_cfg)
    else $error("pll readback wrong");
  a_read_idle: assert property (!bus_req.rd |=> rdata == 8'h00)
    else $error("read data without read");
  a_loop_start: assert property (s_loop_on |-> ##[1:3] loop_running)
    else $error("loop did not start");
  a_coarse_fixed: assert property (loop_running |=> $stable(osc_cal[12:7]))
    else $error("coarse changed while loop active");
  a_fine_step: assert property (loop_running |=> osc_cal[6:0] == $past(osc_cal[6:0]) ||
    osc_cal[6:0] == $past(osc_cal[6:0]) + 7'h01 || osc_cal[6:0] == $past(osc_cal[6:0]) - 7'h01)
    else $error("fine stepped by more than one");
  a_ctrl_busy: assert property (bus_req.rd && bus_req.addr == `OFL_ADDR_CTRL && loop_running |=> rdata[0])
    else $error("enable read zero while loop active");
endmodule

bind ofl_top ofl_properties u_chk (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
  .ext_clk_in(ext_clk_in), .ext_clk_fail_nmi(ext_clk_fail_nmi), .pll_cfg(pll_cfg),
  .pll_src_reserved(pll_src_reserved), .fast_osc_loop_ref_sel0(fast_osc_loop_ref_sel0),
  .fast_osc_loop_ref_sel1(fast_osc_loop_ref_sel1), .mid_osc_loop_ref(mid_osc_loop_ref),
  .slow_osc_trim_value(slow_osc_trim_value), .osc_cal(osc_cal), .loop_running(loop_running));

// ==== tb/testbench.sv ====
// Self-checking bench for the clock configuration block
`timescale 1ns/1ps
`include "ofl_params.svh"
module testbench
  import ofl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  ofl_bus_t bus_req = '0;
  logic cfg_unlock = 1'b0;
  logic ext_run = 1'b1;
  // Calibration values, arbitrary
  ofl_factory_t factory = {8'h5a, 7'h3c, 6'h15};
  logic [7:0] rdata;
  logic [7:0] slow_osc_trim_value;
  logic [12:0] osc_cal;
  ofl_pll_t pll_cfg;
  logic ext_clk_fail_nmi, pll_src_reserved, loop_running;
  logic fast_osc_loop_ref_sel0, fast_osc_loop_ref_sel1, mid_osc_loop_ref;
  logic ext_clk_in, osc_tick, ref_slow_osc, ref_slow_crystal, ref_usb_sof;
  int n_errors = 0;
  int n_checks = 0;
  always #50 clk_sys = ~clk_sys;
  ofl_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .rdata(rdata), .cfg_unlock(cfg_unlock),
    .factory(factory), .ext_clk_in(ext_clk_in), .osc_tick(osc_tick), .ref_slow_osc(ref_slow_osc),
    .ref_slow_crystal(ref_slow_crystal), .ref_usb_sof(ref_usb_sof), .ext_clk_fail_nmi(ext_clk_fail_nmi),
    .pll_cfg(pll_cfg), .pll_src_reserved(pll_src_reserved), .fast_osc_loop_ref_sel0(fast_osc_loop_ref_sel0),
    .fast_osc_loop_ref_sel1(fast_osc_loop_ref_sel1), .mid_osc_loop_ref(mid_osc_loop_ref),
    .slow_osc_trim_value(slow_osc_trim_value), .osc_cal(osc_cal), .loop_running(loop_running));
  ofl_osc_model u_osc (.clk_sys(clk_sys), .nrst(nrst), .ext_run(ext_run), .ext_clk_in(ext_clk_in),
    .osc_tick(osc_tick), .ref_slow_osc(ref_slow_osc), .ref_slow_crystal(ref_slow_crystal),
    .ref_usb_sof(ref_usb_sof));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int i, input int lim);
    if (i >= lim)
    begin
      n_errors++;
      $display("MISMATCH %0t wait timed out", $time);
      end_of_test;
    end
  endtask
  // A idle cycle after each strobe keeps one assignment per signal per step
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
    q = rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(`OFL_ADDR_TRIM, 8'h5a);
    rdc(`OFL_ADDR_FINE, 8'h3c);
    rdc(`OFL_ADDR_COARSE, 8'h15);
    chk(osc_cal, {6'h15, 7'h3c});
    rdc(`OFL_ADDR_CMP_LO, 8'h00);
    rdc(`OFL_ADDR_CMP_HI, 8'h00);
    rdc(`OFL_ADDR_REFSEL, 8'h00);
    rdc(`OFL_ADDR_PLL, 8'h00);
  endtask
  task automatic t_regs;
    logic [7:0] p [5] = '{8'h01, 8'h3f, 8'h9f, 8'hc3, 8'h41};
    logic [7:0] r [4] = '{8'hff, 8'h03, 8'h04, 8'h00};
    foreach (p[k])
    begin
      wr(`OFL_ADDR_PLL, p[k]);
      chk(pll_cfg, p[k]);
      chk(pll_src_reserved, p[k][7:6] == 2'b01);
      rdc(`OFL_ADDR_PLL, p[k]);
    end
    foreach (r[k])
    begin
      wr(`OFL_ADDR_REFSEL, r[k]);
      rdc(`OFL_ADDR_REFSEL, r[k] & 8'h07);
      chk({fast_osc_loop_ref_sel1, fast_osc_loop_ref_sel0, mid_osc_loop_ref}, r[k][2:0]);
    end
    wr(`OFL_ADDR_TRIM, 8'ha5);
    chk(slow_osc_trim_value, 8'ha5);
    wr(`OFL_ADDR_CMP_HI, 8'h12);
    rdc(`OFL_ADDR_CMP_HI, 8'h12);
    wr(`OFL_ADDR_CMP_HI, 8'h00);
    wr(4'h1, 8'hff);
    rdc(4'h1, 8'h00);
  endtask
  task automatic t_fail;
    int i;
    wr(`OFL_ADDR_FAIL, 8'h01);
    rdc(`OFL_ADDR_FAIL, 8'h00);
    cfg_unlock <= 1'b1;
    wr(`OFL_ADDR_FAIL, 8'h01);
    rdc(`OFL_ADDR_FAIL, 8'h01);
    ext_run <= 1'b0;
    for (i = 0; i < 200 && ext_clk_fail_nmi !== 1'b1; i++)
      @(posedge clk_sys);
    guard(i, 200);
    chk(i > `OFL_FAIL_TIMEOUT_CYC - 6 && i < `OFL_FAIL_TIMEOUT_CYC + 6, 1'b1);
    wr(`OFL_ADDR_FAIL, 8'h00);
    cfg_unlock <= 1'b0;
    wr(`OFL_ADDR_FAIL, 8'h02);
    rdc(`OFL_ADDR_FAIL, 8'h03);
    ext_run <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(`OFL_ADDR_FAIL, 8'h02);
    rdc(`OFL_ADDR_FAIL, 8'h01);
    chk(ext_clk_fail_nmi, 1'b0);
  endtask
  task automatic t_loop;
    int i;
    // Count per period is ten, so a large compare drives fine upward
    wr(`OFL_ADDR_CMP_LO, 8'hff);
    wr(`OFL_ADDR_FINE, 8'h40);
    wr(`OFL_ADDR_COARSE, 8'h2a);
    chk(osc_cal, {6'h2a, 7'h40});
    wr(`OFL_ADDR_CTRL, 8'h01);
    wr(`OFL_ADDR_COARSE, 8'h01);
    wr(`OFL_ADDR_FINE, 8'h00);
    repeat (100) @(posedge clk_sys);
    rdc(`OFL_ADDR_COARSE, 8'h2a);
    chk(osc_cal[6:0] > 7'h40 && osc_cal[6:0] < 7'h47, 1'b1);
    for (i = 0; i < 40 && ref_slow_osc !== 1'b1; i++)
      @(posedge clk_sys);
    guard(i, 40);
    wr(`OFL_ADDR_CTRL, 8'h00);
    rdc(`OFL_ADDR_CTRL, 8'h01);
    for (i = 0; i < 40 && loop_running !== 1'b0; i++)
      @(posedge clk_sys);
    guard(i, 40);
    rdc(`OFL_ADDR_CTRL, 8'h00);
    wr(`OFL_ADDR_FINE, 8'h11);
    rdc(`OFL_ADDR_FINE, 8'h11);
    // Zero compare against ten ticks per period steps fine downward, on the crystal reference
    wr(`OFL_ADDR_CMP_LO, 8'h00);
    wr(`OFL_ADDR_REFSEL, 8'h02);
    wr(`OFL_ADDR_CTRL, 8'h01);
    repeat (100) @(posedge clk_sys);
    chk(osc_cal[6:0] < 7'h11 && osc_cal[6:0] > 7'h0a, 1'b1);
    wr(`OFL_ADDR_CTRL, 8'h00);
    for (i = 0; i < 40 && loop_running !== 1'b0; i++)
      @(posedge clk_sys);
    guard(i, 40);
    rdc(`OFL_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_rerst;
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rdc(`OFL_ADDR_FAIL, 8'h00);
    rdc(`OFL_ADDR_TRIM, 8'h5a);
    rdc(`OFL_ADDR_FINE, 8'h3c);
    rdc(`OFL_ADDR_REFSEL, 8'h00);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_reset;
    t_regs;
    t_fail;
    t_loop;
    t_rerst;
    end_of_test;
  end
endmodule
